/* File: core/kmic_ctrl.sv */
// Operation
// - short 60 ms to 2 s, long beyond
// - short press when off starts boost, display
// - display ends 4 s, lowest led blinks 0.5 Hz
// - short press in boost redisplays 4 s
// - full battery or 16 s no load shuts down
// - below 3.5 V short press: fast alert 4 s
// - boost cuts out below 3.1 V
// - long press toggles torch
// - below 3.1 V torch and boost refused
// - lit torch stays on at low battery
// - charging ignores short, honours long presses
// - level shown on four leds, 25% each
// - charging blinks band led 1 Hz, full all lit
// - charger input drops output, new press needed
`timescale 1ns/1ps

module kmic_ctrl
   import kmic_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
   // clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   // button, low while pressed
   input wire logic KEY_N,
   // analog front end flags
   input wire logic CHARGER_IN,
   input wire logic CHARGE_FULL,
   input wire logic LOAD_PRESENT,
   input wire logic BAT_BELOW_3V5,
   input wire logic BAT_BELOW_3V1,
   input wire logic [1:0] BAT_LEVEL_BAND,
   // outputs
   output logic [LED_N-1:0] LEVEL_LED_BAR,
   output logic BOOST_EN,
   output logic TORCH_EN
);
   localparam int TICK_W = $clog2(TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   logic [ST_W-1:0] st_raw;
   logic [ST_W-1:0] st_meta;
   logic [ST_W-1:0] st_sync;
   logic charging;
   logic full;
   logic load;
   logic low35;
   logic low31;
   logic [1:0] band;
   logic [LED_N-1:0] bar;
   logic [LED_N-1:0] band_led;
   logic [TICK_W-1:0] tick_cnt;
   logic tick;
   logic [MS_W-1:0] slow_ms;
   logic [FAST_W-1:0] fast_ms;
   logic slow_on;
   logic chg_on;
   logic [LED_N-1:0] fast_led;
   logic short_press;
   logic long_press;
   kmic_state_t state;
   kmic_state_t next_state;
   logic [MS_W-1:0] disp_ms;
   logic disp_alert;
   logic [IDLE_W-1:0] idle_ms;
   logic [LED_N-1:0] next_led;

   // ==========================================================
   // input synchronisers
   // band bits are synchronised apart; a one-cycle mixed code at a band edge is harmless
   assign st_raw = {BAT_LEVEL_BAND, BAT_BELOW_3V1, BAT_BELOW_3V5, LOAD_PRESENT, CHARGE_FULL, CHARGER_IN};

   generate
      for (genvar i = 0; i < ST_W; i++)
      begin : g_sync
         always_ff @(posedge CLK_SYS or posedge RST)
         begin
            if (RST)
            begin
               st_meta[i] <= 1'b0;
               st_sync[i] <= 1'b0;
            end
            else if (CE)
            begin
               st_meta[i] <= st_raw[i];
               st_sync[i] <= st_meta[i];
            end
         end
      end
   endgenerate

   assign charging = st_sync[ST_CHARGING];
   assign full = st_sync[ST_FULL];
   assign load = st_sync[ST_LOAD];
   assign low35 = st_sync[ST_LOW35];
   assign low31 = st_sync[ST_LOW31];
   assign band = st_sync[ST_BAND+1:ST_BAND];

   // thermometer bar, one led per quarter
   generate
      for (genvar i = 0; i < LED_N; i++)
      begin : g_bar
         assign bar[i] = band >= 2'(i);
      end
   endgenerate

   assign band_led = LED_N'(LED_LOW << band);

   // ==========================================================
   // millisecond timebase and flash phases
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end
      else if (CE)
      begin
         tick <= tick_cnt == TICK_LAST;
         tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + TICK_W'(1);
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         slow_ms <= '0;
         fast_ms <= '0;
      end
      else if (CE && tick)
      begin
         slow_ms <= (slow_ms == SLOW_PERIOD_MS - 12'h001) ? '0 : slow_ms + 12'h001;
         fast_ms <= (fast_ms == FAST_PERIOD_MS - 8'h01) ? '0 : fast_ms + 8'h01;
      end
   end

   assign slow_on = slow_ms < SLOW_ON_MS;
   assign chg_on = slow_ms < CHG_ON_MS || (slow_ms >= CHG_PERIOD_MS && slow_ms < CHG_ON2_MS);
   assign fast_led = (fast_ms < FAST_ON_MS) ? LED_LOW : LED_NONE;

   // ==========================================================
   // key classifier
   kmic_key u_key
   (
      .clk_sys(CLK_SYS),
      .rst(RST),
      .ce(CE),
      .tick(tick),
      .key_n(KEY_N),
      .short_press(short_press),
      .long_press(long_press)
   );

   // ==========================================================
   // operating mode
   always_comb
   begin
      next_state = state;
      unique case (state)
         KMIC_OFF:
         begin
            if (short_press && !low31)
               next_state = KMIC_BOOST;
         end
         KMIC_BOOST:
         begin
            if (full || idle_ms >= NOLOAD_MS)
               next_state = KMIC_OFF;
            if (low31)
               next_state = KMIC_OFF;
         end
         KMIC_CHARGE:
         begin
            // back to off, not boost: a new press is needed
            if (!charging)
               next_state = KMIC_OFF;
         end
         default:
            next_state = KMIC_OFF;
      endcase
      if (charging)
         next_state = KMIC_CHARGE;
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         state <= KMIC_OFF;
         BOOST_EN <= 1'b0;
      end
      else if (CE)
      begin
         state <= next_state;
         BOOST_EN <= next_state == KMIC_BOOST;
      end
   end
   a_short_powers_up: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_OFF && short_press && !low31 && !charging) |=> BOOST_EN && disp_ms == DISP_MS)
      else $error("short press from off did not start boost");
   a_lowbat_cutoff: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_BOOST && low31) |=> !BOOST_EN)
      else $error("boost not cut at low battery");
   a_refuse_low: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && low31 && !TORCH_EN && state == KMIC_OFF) |=> !TORCH_EN && !BOOST_EN)
      else $error("turn-on accepted at low battery");
   a_charger_drop: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && charging) |=> !BOOST_EN ##1 (state != KMIC_BOOST))
      else $error("output path kept with charger present");

   // ==========================================================
   // no-load timer
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         idle_ms <= '0;
      else if (CE)
      begin
         if (state != KMIC_BOOST || load)
            idle_ms <= '0;
         else if (tick && idle_ms != NOLOAD_MS)
            idle_ms <= idle_ms + 15'h0001;
      end
   end
   a_noload_shutdown: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_BOOST && (full || idle_ms == NOLOAD_MS)) |=> !BOOST_EN)
      else $error("boost stayed on after full or idle");

   // ==========================================================
   // display timer
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         disp_ms <= '0;
         disp_alert <= 1'b0;
      end
      else if (CE)
      begin
         if (next_state == KMIC_CHARGE || (state == KMIC_BOOST && next_state == KMIC_OFF))
         begin
            disp_ms <= '0;
            disp_alert <= 1'b0;
         end
         else if (short_press)
         begin
            disp_ms <= DISP_MS;
            disp_alert <= low35;
         end
         else if (tick && disp_ms != '0)
            disp_ms <= disp_ms - 12'h001;
      end
   end
   a_redisplay_keeps: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_BOOST && short_press && next_state == KMIC_BOOST) |=> BOOST_EN && disp_ms == DISP_MS)
      else $error("short press in boost mishandled");
   a_low_alert: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && short_press && low35 && next_state != KMIC_CHARGE && state != KMIC_BOOST) |=> disp_alert)
      else $error("low battery alert not raised");
   a_charge_mask: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_CHARGE && charging) |=> !BOOST_EN && disp_ms == '0)
      else $error("short press acted during charge");

   // ==========================================================
   // torch
   // no low-battery turn-off, only a long press ends it
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         TORCH_EN <= 1'b0;
      else if (CE && long_press)
      begin
         if (TORCH_EN)
            TORCH_EN <= 1'b0;
         else if (!low31)
            TORCH_EN <= 1'b1;
      end
   end
   a_torch_toggle: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && long_press && TORCH_EN) |=> !TORCH_EN)
      else $error("long press did not turn torch off");
   a_torch_holds: assert property (@(posedge CLK_SYS) disable iff (RST)
      (TORCH_EN && !(CE && long_press)) |=> TORCH_EN)
      else $error("torch dropped without long press");

   // ==========================================================
   // indicator leds
   always_comb
   begin
      next_led = LED_NONE;
      unique case (state)
         KMIC_CHARGE:
         begin
            next_led = full ? LED_ALL : ((bar & ~band_led) | (chg_on ? band_led : LED_NONE));
         end
         KMIC_BOOST:
         begin
            if (disp_ms != '0)
               next_led = disp_alert ? fast_led : bar;
            else
               next_led = slow_on ? LED_LOW : LED_NONE;
         end
         KMIC_OFF:
         begin
            if (disp_ms != '0 && disp_alert)
               next_led = fast_led;
         end
         default:
            next_led = LED_NONE;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         LEVEL_LED_BAR <= LED_NONE;
      else if (CE)
         LEVEL_LED_BAR <= next_led;
   end

   a_boost_blink_only: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_BOOST && disp_ms == '0) |=> LEVEL_LED_BAR[LED_N-1:1] == LED_NONE[LED_N-1:1])
      else $error("upper leds lit after display ended");
   a_level_bar: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_BOOST && disp_ms != '0 && !disp_alert) |=> LEVEL_LED_BAR == $past(bar))
      else $error("level bar does not match band");
   a_full_steady: assert property (@(posedge CLK_SYS) disable iff (RST)
      (CE && state == KMIC_CHARGE && full) |=> LEVEL_LED_BAR == LED_ALL)
      else $error("end of charge not all lit");
endmodule

/* File: core/kmic_key.sv */
`timescale 1ns/1ps

// ==========================================================
// shared constants
package kmic_pkg;
   // timebase: one tick per millisecond
   localparam int CLK_MHZ = 200;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES_DEF = CLK_MHZ * TICK_US;

   // millisecond timers
   localparam int MS_W = 12;
   localparam logic [MS_W-1:0] SHORT_MIN_MS = 12'd60;
   localparam logic [MS_W-1:0] LONG_MS = 12'd2000;
   localparam logic [MS_W-1:0] LONG_SAT_MS = LONG_MS + 12'd1;
   localparam logic [MS_W-1:0] DISP_MS = 12'd4000;
   localparam int IDLE_W = 15;
   localparam logic [IDLE_W-1:0] NOLOAD_MS = 15'd16000;

   // flash patterns
   localparam logic [MS_W-1:0] SLOW_PERIOD_MS = 12'd2000;
   localparam logic [MS_W-1:0] SLOW_ON_MS = 12'd250;
   localparam logic [MS_W-1:0] CHG_PERIOD_MS = 12'd1000;
   localparam logic [MS_W-1:0] CHG_ON_MS = 12'd500;
   localparam logic [MS_W-1:0] CHG_ON2_MS = CHG_PERIOD_MS + CHG_ON_MS;
   localparam int FAST_W = 8;
   localparam logic [FAST_W-1:0] FAST_PERIOD_MS = 8'd250;
   localparam logic [FAST_W-1:0] FAST_ON_MS = 8'd125;

   // indicator patterns
   localparam int LED_N = 4;
   localparam logic [LED_N-1:0] LED_NONE = 4'h0;
   localparam logic [LED_N-1:0] LED_LOW = 4'h1;
   localparam logic [LED_N-1:0] LED_ALL = 4'hF;

   // status input vector layout
   localparam int ST_W = 7;
   localparam int ST_CHARGING = 0;
   localparam int ST_FULL = 1;
   localparam int ST_LOAD = 2;
   localparam int ST_LOW35 = 3;
   localparam int ST_LOW31 = 4;
   localparam int ST_BAND = 5;

   typedef enum logic [1:0]
   {
      KMIC_OFF = 2'b00,
      KMIC_BOOST = 2'b01,
      KMIC_CHARGE = 2'b10
   } kmic_state_t;
endpackage

// ==========================================================
// key press classifier
module kmic_key
   import kmic_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // timebase
   input wire logic tick,
   // button pin, low while pressed
   input wire logic key_n,
   // classified presses
   output logic short_press,
   output logic long_press
);
   logic [1:0] key_sync;
   logic pressed;
   logic pressed_d;
   logic [MS_W-1:0] hold_ms;

   assign pressed = key_sync[1];

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         key_sync <= 2'h0;
      end
      else if (ce)
      begin
         key_sync <= {key_sync[0], ~key_n};
      end
   end

   // saturates just past the long threshold so the long action fires once
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         hold_ms <= '0;
         pressed_d <= 1'b0;
      end
      else if (ce)
      begin
         pressed_d <= pressed;
         if (!pressed)
            hold_ms <= '0;
         else if (tick && hold_ms != LONG_SAT_MS)
            hold_ms <= hold_ms + 12'h001;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         short_press <= 1'b0;
         long_press <= 1'b0;
      end
      else if (ce)
      begin
         short_press <= pressed_d && !pressed && hold_ms > SHORT_MIN_MS && hold_ms <= LONG_MS;
         long_press <= pressed && tick && hold_ms == LONG_MS;
      end
   end
endmodule

/* File: test/kmic_button.sv */
`timescale 1ns/1ps

// ==========================================================
// push button operator, bounce-free
module kmic_button
#(
   parameter int TICK_CYCLES = 2
)
(
   // clock
   input wire logic clk_sys,
   // button pin, pulled up while released
   output logic key_n
);
   initial key_n = 1'b1;

   // edges land 1 ns after the clock so the synchroniser never races
   task down();
      @(posedge clk_sys);
      #1 key_n = 1'b0;
   endtask

   task up();
      @(posedge clk_sys);
      #1 key_n = 1'b1;
   endtask

   task push(input int ms);
      down();
      repeat (ms * TICK_CYCLES) @(posedge clk_sys);
      up();
   endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps

// ==========================================================
// bench top
module tb;
   import kmic_pkg::*;
   localparam int TC = 2;
   logic clk_sys;
   logic rst;
   logic ce;
   logic chg;
   logic full;
   logic load;
   logic b35;
   logic b31;
   logic [1:0] band;
   wire key_n;
   logic [LED_N-1:0] bar;
   logic boost;
   logic torch;
   logic [15:0] c0;
   logic [15:0] c1;
   int n_mismatch = 0;
   int cmp_count = 0;

   kmic_ctrl #(.TICK_CYCLES(TC)) u_dut (
      .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .KEY_N(key_n), .CHARGER_IN(chg),
      .CHARGE_FULL(full), .LOAD_PRESENT(load), .BAT_BELOW_3V5(b35), .BAT_BELOW_3V1(b31),
      .BAT_LEVEL_BAND(band), .LEVEL_LED_BAR(bar), .BOOST_EN(boost), .TORCH_EN(torch)
   );

   kmic_button #(.TICK_CYCLES(TC)) u_btn (.clk_sys(clk_sys), .key_n(key_n));

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // helpers
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task ticks(input int n);
      repeat (n * TC) @(posedge clk_sys);
      #1;
   endtask

   // release reaches the outputs about 4 edges later
   task settle();
      repeat (10) @(posedge clk_sys);
      #1;
   endtask

   task count_on(input int n);
      c0 = 16'h0000;
      c1 = 16'h0000;
      repeat (n * TC)
      begin
         @(posedge clk_sys);
         #1;
         c0 = c0 + {15'h0000, bar[0]};
         c1 = c1 + {15'h0000, bar[1]};
      end
   endtask

   task report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task t_boost();
      u_btn.push(100);
      settle();
      chk(boost, 1'b1);
      chk(bar, 4'h7);
      ticks(4010);
      count_on(2000);
      chk(c0, 16'(250 * TC));
      chk(c1, 16'h0000);
      $display("test boost done");
   endtask

   task t_redisplay();
      band = 2'h3;
      u_btn.push(30);
      settle();
      chk(bar[3:1], 3'h0);
      u_btn.push(100);
      settle();
      chk(bar, 4'hF);
      chk(boost, 1'b1);
      $display("test redisplay done");
   endtask

   task t_noload();
      load = 1'b0;
      ticks(15900);
      chk(boost, 1'b1);
      ticks(200);
      chk(boost, 1'b0);
      load = 1'b1;
      $display("test noload done");
   endtask

   task t_lowbat();
      b35 = 1'b1;
      band = 2'h0;
      u_btn.push(100);
      settle();
      chk(boost, 1'b1);
      count_on(250);
      chk(c0, 16'(125 * TC));
      chk(c1, 16'h0000);
      u_btn.down();
      ticks(2010);
      chk(torch, 1'b1);
      u_btn.up();
      settle();
      b31 = 1'b1;
      settle();
      chk(boost, 1'b0);
      chk(torch, 1'b1);
      u_btn.push(2010);
      settle();
      chk(torch, 1'b0);
      u_btn.push(2010);
      settle();
      chk(torch, 1'b0);
      u_btn.push(100);
      settle();
      chk(boost, 1'b0);
      b31 = 1'b0;
      b35 = 1'b0;
      $display("test lowbat done");
   endtask

   task t_charge();
      u_btn.push(100);
      settle();
      chg = 1'b1;
      settle();
      chk(boost, 1'b0);
      u_btn.push(100);
      settle();
      chk(boost, 1'b0);
      u_btn.push(2010);
      settle();
      chk(torch, 1'b1);
      band = 2'h1;
      ticks(5);
      count_on(1000);
      chk(c0, 16'(1000 * TC));
      chk(c1, 16'(500 * TC));
      full = 1'b1;
      settle();
      chk(bar, 4'hF);
      full = 1'b0;
      chg = 1'b0;
      settle();
      chk(boost, 1'b0);
      u_btn.push(100);
      settle();
      chk(boost, 1'b1);
      full = 1'b1;
      settle();
      chk(boost, 1'b0);
      chk(bar, 4'h0);
      $display("test charge done");
   endtask

   // frozen enable must hold off the cutoff; a mid-run reset must clear all outputs
   task t_freeze_reset();
      full = 1'b0;
      u_btn.push(100);
      settle();
      chk(boost, 1'b1);
      ce = 1'b0;
      b31 = 1'b1;
      settle();
      chk(boost, 1'b1);
      chk(bar, 4'h3);
      ce = 1'b1;
      settle();
      chk(boost, 1'b0);
      chk(torch, 1'b1);
      b31 = 1'b0;
      rst = 1'b1;
      ticks(1);
      chk({bar, boost, torch}, 6'h00);
      rst = 1'b0;
      u_btn.push(100);
      settle();
      chk(boost, 1'b1);
      chk(bar, 4'h3);
      $display("test freeze and reset done");
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      chg = 1'b0;
      full = 1'b0;
      load = 1'b1;
      b35 = 1'b0;
      b31 = 1'b0;
      band = 2'h2;
      repeat (2) @(posedge clk_sys);
      #1;
      chk({bar, boost, torch}, 6'h00);
      rst = 1'b0;
      t_boost();
      t_redisplay();
      t_noload();
      t_lowbat();
      t_charge();
      t_freeze_reset();
      report_and_stop();
   end

   // about 65k cycles expected, cut at 90k
   initial
   begin
      #450000;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule
